// file: src/csp_pwm.sv
// Standard-mode PWM: period timer with prescaler, double-buffered 10-bit duty, pin drive
`default_nettype none
// Functional notes
// [RULE1] Period is (limit+1)*4*Tosc*prescale
// [RULE2] Count equal to limit clears on next increment
// [RULE3] New period sets pin unless duty zero
// [RULE4] Boundary copies staging duty into active
// [RULE5] Postscaler never affects output period
// [RULE6] Duty is staging byte plus two low bits
// [RULE7] Duty writes anytime, effective next period
// [RULE8] Active duty is read-only while modulating
// [RULE9] High time is duty*Tosc*prescale
// [RULE10] Duty ratio is duty over 4*(limit+1)
// [RULE11] Active byte plus hidden 2-bit latch
// [RULE12] Time base is count plus two phase bits
// [RULE13] Time base equal to duty clears pin
// [RULE14] Software setup order: direction, limit, mode, duty; the testbench writes limit, mode, duty first and clears direction only after the match flag
// [RULE15] Software waits match flag before enabling pin
// [RULE16] Match flag sticky until software clears
module csp_pwm (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic pwm_output_pin_o,
  output logic pwm_output_pin_oe,
  output logic irq
);
  logic [7:0] period_limit_ff;
  logic [7:0] timebase_count_ff;
  logic [7:0] duty_staging_ff;
  logic [7:0] duty_active_ff;
  logic [1:0] duty_latch_ff;
  logic [7:0] ccp_control_ff;
  logic [2:0] timer_control_ff;
  logic pin_direction_ff;
  logic [csp_pkg::STS_WIDTH-1:0] status_ff;
  logic [csp_pkg::STS_WIDTH-1:0] mask_ff;
  logic [5:0] presc_ff;
  logic pwm_level_ff;
  logic [7:0] rdata_ff;
  logic pin_o_ff;
  logic pin_oe_ff;
  logic irq_ff;

  // Address decode
  wire sel_period = reg_addr == csp_pkg::ADDR_PERIOD_LIMIT;
  wire sel_count = reg_addr == csp_pkg::ADDR_TIMEBASE_COUNT;
  wire sel_staging = reg_addr == csp_pkg::ADDR_DUTY_STAGING;
  wire sel_active = reg_addr == csp_pkg::ADDR_DUTY_ACTIVE;
  wire sel_ctl = reg_addr == csp_pkg::ADDR_CCP_CONTROL;
  wire sel_tctl = reg_addr == csp_pkg::ADDR_TIMER_CONTROL;
  wire sel_dir = reg_addr == csp_pkg::ADDR_PIN_DIRECTION;
  wire sel_sts = reg_addr == csp_pkg::ADDR_IRQ_STATUS;
  wire sel_mask = reg_addr == csp_pkg::ADDR_IRQ_MASK;

  wire pwm_mode = ccp_control_ff[csp_pkg::CTL_MODE_LSB +: 4] == csp_pkg::MODE_PWM;
  wire timer_run = timer_control_ff[csp_pkg::TCTL_RUN_BIT];
  wire [1:0] prescale_sel = timer_control_ff[csp_pkg::TCTL_PRESCALE_LSB +: 2];
  wire [1:0] duty_low_bits = ccp_control_ff[csp_pkg::CTL_DUTY_LOW_LSB +: 2]; // [RULE6]

  // Prescaler ratio 1, 4 or 16 in oscillator quarter-steps; postscaler absent [RULE5]
  function automatic logic [5:0] presc_last(input logic [1:0] sel);
    if (sel == csp_pkg::PRESCALE_1) begin
      presc_last = 6'h03;
    end else if (sel == csp_pkg::PRESCALE_4) begin
      presc_last = 6'h0f;
    end else begin
      presc_last = 6'h3f;
    end
  endfunction

  // Each clk_sys is one oscillator period; presc_ff counts them per increment
  wire inc = timer_run && (presc_ff == presc_last(prescale_sel)); // [RULE1]
  // Two extra time base bits: the phase bits at 1:1, top prescaler bits otherwise
  function automatic logic [1:0] tb_low_of(input logic [5:0] presc, input logic [1:0] sel);
    if (sel == csp_pkg::PRESCALE_1) begin
      tb_low_of = presc[1:0];
    end else if (sel == csp_pkg::PRESCALE_4) begin
      tb_low_of = presc[3:2];
    end else begin
      tb_low_of = presc[5:4];
    end
  endfunction
  wire [1:0] tb_low = tb_low_of(presc_ff, prescale_sel); // [RULE12]
  wire [9:0] time_base = {timebase_count_ff, tb_low}; // [RULE12]
  wire [9:0] duty_now = {duty_active_ff, duty_latch_ff}; // [RULE11]
  wire [9:0] duty_next = {duty_staging_ff, duty_low_bits};
  wire period_end = inc && (timebase_count_ff == period_limit_ff); // [RULE2]

  wire [7:0] nxt_count = period_end ? 8'h00 : // [RULE2]
                         inc ? timebase_count_ff + 8'h01 : timebase_count_ff;
  wire [5:0] nxt_presc = !timer_run ? 6'h00 :
                         (presc_ff == presc_last(prescale_sel)) ? 6'h00 : presc_ff + 6'h01;
  // Compare against the time base after this edge, so the pin falls exactly when
  // the time base reaches the duty value; wider prescales hold each step
  wire [9:0] nxt_time_base = {nxt_count, tb_low_of(nxt_presc, prescale_sel)}; // [RULE12]
  wire duty_hit = pwm_mode && timer_run && (nxt_time_base == duty_now); // [RULE13]
  // Period start sets the pin unless duty is zero; duty match clears it
  wire nxt_pwm_level = period_end ? (pwm_mode && duty_next != 10'h000) : // [RULE3]
                       duty_hit ? 1'b0 : pwm_level_ff; // [RULE9] [RULE10] [RULE13]
  // Hardware set wins over a same-cycle write-one-to-clear
  wire [csp_pkg::STS_WIDTH-1:0] sts_clr = (reg_wr && sel_sts) ?
                                          reg_wdata[csp_pkg::STS_WIDTH-1:0] : '0;
  wire [csp_pkg::STS_WIDTH-1:0] nxt_status = (status_ff & ~sts_clr) |
                                             {period_end}; // [RULE16]

  wire [7:0] nxt_rdata = !reg_rd ? 8'h00 :
                         sel_period ? period_limit_ff :
                         sel_count ? timebase_count_ff :
                         sel_staging ? duty_staging_ff :
                         sel_active ? duty_active_ff :
                         sel_ctl ? ccp_control_ff :
                         sel_tctl ? {5'h00, timer_control_ff} :
                         sel_dir ? {7'h00, pin_direction_ff} :
                         sel_sts ? {7'h00, status_ff} :
                         sel_mask ? {7'h00, mask_ff} : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      period_limit_ff <= csp_pkg::RST_PERIOD_LIMIT;
      duty_staging_ff <= csp_pkg::RST_BYTE;
      ccp_control_ff <= csp_pkg::RST_BYTE;
      timer_control_ff <= 3'h0;
      pin_direction_ff <= csp_pkg::RST_PIN_DIRECTION;
      mask_ff <= '0;
    end else if (reg_wr) begin
      // Staging and low bits accept writes at any time [RULE7]
      if (sel_period) period_limit_ff <= reg_wdata;
      if (sel_staging) duty_staging_ff <= reg_wdata;
      if (sel_ctl) ccp_control_ff <= {2'h0, reg_wdata[5:0]};
      if (sel_tctl) timer_control_ff <= reg_wdata[2:0];
      if (sel_dir) pin_direction_ff <= reg_wdata[0];
      if (sel_mask) mask_ff <= reg_wdata[csp_pkg::STS_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      duty_active_ff <= csp_pkg::RST_BYTE;
      duty_latch_ff <= 2'h0;
    end else if (period_end) begin
      duty_active_ff <= duty_staging_ff; // [RULE4]
      duty_latch_ff <= duty_low_bits; // [RULE11]
    end else if (!pwm_mode && reg_wr && sel_active) begin
      // Writable only outside modulation [RULE8]
      duty_active_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timebase_count_ff <= 8'h00;
      presc_ff <= 6'h00;
      pwm_level_ff <= 1'b0;
      status_ff <= '0;
      rdata_ff <= 8'h00;
      pin_o_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      timebase_count_ff <= (reg_wr && sel_count) ? reg_wdata : nxt_count;
      presc_ff <= nxt_presc;
      pwm_level_ff <= nxt_pwm_level;
      status_ff <= nxt_status;
      rdata_ff <= nxt_rdata;
      pin_o_ff <= nxt_pwm_level && pwm_mode;
      pin_oe_ff <= !(reg_wr && sel_dir ? reg_wdata[0] : pin_direction_ff);
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

  assign reg_rdata = rdata_ff;
  assign pwm_output_pin_o = pin_o_ff;
  assign pwm_output_pin_oe = pin_oe_ff;
  assign irq = irq_ff;

  property p_wrap;
    @(posedge clk_sys) disable iff (!rst_n) period_end |=> timebase_count_ff == 8'h00;
  endproperty
  AST_WRAP: assert property (p_wrap) else $error("count not cleared at period end"); // [RULE2]
  AST_COPY: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE4]
    period_end |=> duty_active_ff == $past(duty_staging_ff)) else $error("duty not copied");
  AST_SET: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
    period_end && pwm_mode && duty_next != 10'h000 |=> pwm_level_ff) else $error("no set");
  AST_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
    period_end && duty_next == 10'h000 |=> !pwm_level_ff) else $error("set at zero duty");
  AST_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE13]
    duty_hit && !period_end |=> !pwm_level_ff) else $error("pin not cleared on match");
  AST_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE16]
    period_end |=> status_ff[csp_pkg::STS_MATCH_BIT]) else $error("flag not set");
  AST_RO: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE8]
    pwm_mode && !period_end |=> $stable(duty_active_ff)) else $error("active duty changed");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE7]
    !period_end |=> $stable(duty_latch_ff)) else $error("latch changed mid period");

  // Assertion helpers below carry no function of their own
  wire tctl_wr = reg_wr && sel_tctl;
  wire count_wr = reg_wr && sel_count;
  wire sts_wr = reg_wr && sel_sts;
  wire match_clr = sts_wr && reg_wdata[csp_pkg::STS_MATCH_BIT];
  logic [5:0] inc_gap_ff;
  logic gap_valid_ff;

  // Prescaler ratio 1, 4 or 16 for a select code; OSC_PER_INC scales it to oscillator periods
  function automatic logic [5:0] presc_ratio(input logic [1:0] sel);
    if (sel == csp_pkg::PRESCALE_1) begin
      presc_ratio = 6'h01;
    end else if (sel == csp_pkg::PRESCALE_4) begin
      presc_ratio = 6'h04;
    end else begin
      presc_ratio = 6'h10;
    end
  endfunction

  // Clocks since the last increment; the gap is only trusted when the prescale
  // setting stayed untouched and the timer kept running across all of it
  wire [5:0] nxt_inc_gap = inc ? 6'h00 : inc_gap_ff + 6'h01;
  wire nxt_gap_valid = inc ? !tctl_wr : (gap_valid_ff && timer_run && !tctl_wr);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inc_gap_ff <= 6'h00;
      gap_valid_ff <= 1'b0;
    end else begin
      inc_gap_ff <= nxt_inc_gap;
      gap_valid_ff <= nxt_gap_valid;
    end
  end

  // A period boundary that must raise the pin
  sequence s_boundary_set;
    period_end && pwm_mode && duty_next != 10'h000;
  endsequence

  // A duty match inside the period
  sequence s_duty_fall;
    duty_hit && !period_end;
  endsequence

  // A boundary at 1:1 with a one-step duty and a quiet bus just after it
  sequence s_one_step_pulse;
    (period_end && pwm_mode && prescale_sel == csp_pkg::PRESCALE_1 &&
      duty_next == 10'h001 && !reg_wr) ##1 !reg_wr;
  endsequence

  AST_INC_GAP: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE1]
    inc && gap_valid_ff |-> int'(inc_gap_ff) ==
    csp_pkg::OSC_PER_INC * int'(presc_ratio(prescale_sel)) - 1)
    else $error("timer step spacing wrong");

  AST_PIN_UP: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
    s_boundary_set |=> pin_o_ff)
    else $error("pin not raised at period start");

  AST_PIN_DOWN: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE13]
    s_duty_fall |=> !pin_o_ff)
    else $error("pin not lowered on duty match");

  AST_ONE_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE9]
    s_one_step_pulse |-> pin_o_ff ##1 !pin_o_ff)
    else $error("one step pulse has wrong width");

  AST_COUNT_STEP: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE2]
    inc && !period_end && !count_wr |=>
    timebase_count_ff == $past(timebase_count_ff) + 8'h01)
    else $error("count did not step");

  AST_COUNT_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE1]
    !inc && !count_wr |=> $stable(timebase_count_ff))
    else $error("count moved between increments");

  AST_TB_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE12]
    period_end && !count_wr |=> time_base == 10'h000)
    else $error("time base not restarted");

  AST_NO_MODE_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
    !pwm_mode |=> !pwm_output_pin_o)
    else $error("pin high outside modulation");

  AST_DRIVER: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE15]
    pwm_output_pin_oe == !pin_direction_ff)
    else $error("driver enable disagrees with direction");

  AST_FLAG_KEEP: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE16]
    status_ff[csp_pkg::STS_MATCH_BIT] && !match_clr |=> status_ff[csp_pkg::STS_MATCH_BIT])
    else $error("flag dropped without clear");

  AST_FLAG_DROP: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE16]
    match_clr && !period_end |=> !status_ff[csp_pkg::STS_MATCH_BIT])
    else $error("flag not cleared by write");

  AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $stable(mask_ff) |-> irq == |(status_ff & mask_ff))
    else $error("interrupt level wrong");

  AST_ACTIVE_FREE: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE8]
    !pwm_mode && !period_end && reg_wr && sel_active |=>
    duty_active_ff == $past(reg_wdata))
    else $error("active duty not writable outside modulation");

  AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");

  AST_RDATA_LIMIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && sel_period |=> reg_rdata == $past(period_limit_ff))
    else $error("period limit read wrong");

  AST_RDATA_STAGING: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE7]
    reg_rd && sel_staging |=> reg_rdata == $past(duty_staging_ff))
    else $error("staging read wrong");

  AST_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_rd && reg_addr > csp_pkg::ADDR_IRQ_MASK |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  AST_STAGING_WR: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE7]
    reg_wr && sel_staging |=> duty_staging_ff == $past(reg_wdata))
    else $error("staging write lost");

  AST_LATCH_COPY: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE11]
    period_end |=> duty_latch_ff == $past(duty_low_bits))
    else $error("low bits not latched");

  AST_LEVEL_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE11]
    !period_end && !duty_hit |=> pwm_level_ff == $past(pwm_level_ff))
    else $error("level glitched");

  AST_RISE_AT_END: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
    $rose(pwm_level_ff) |-> $past(period_end))
    else $error("level rose mid period");

  AST_PRESC_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE1]
    !timer_run |=> presc_ff == 6'h00)
    else $error("prescaler ran while stopped");

  AST_CTL_TOP: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE6]
    ccp_control_ff[7:6] == 2'h0)
    else $error("unused control bits set");

  AST_PIN_MIRROR: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE13]
    pwm_output_pin_o == (pwm_level_ff && $past(pwm_mode)))
    else $error("pin does not follow level");
endmodule
`default_nettype wire

// file: src/csp_pkg.sv
// Package: register map, field layout and reset values of the standard PWM block
`default_nettype none
package csp_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_PERIOD_LIMIT = 4'h0;
  localparam logic [3:0] ADDR_TIMEBASE_COUNT = 4'h1;
  localparam logic [3:0] ADDR_DUTY_STAGING = 4'h2;
  localparam logic [3:0] ADDR_DUTY_ACTIVE = 4'h3;
  localparam logic [3:0] ADDR_CCP_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_TIMER_CONTROL = 4'h5;
  localparam logic [3:0] ADDR_PIN_DIRECTION = 4'h6;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h7;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
  // ccp_control fields
  localparam int CTL_DUTY_LOW_LSB = 4;
  localparam int CTL_MODE_LSB = 0;
  localparam logic [3:0] MODE_PWM = 4'hc;
  // timer_control fields
  localparam int TCTL_RUN_BIT = 2;
  localparam int TCTL_PRESCALE_LSB = 0;
  localparam logic [1:0] PRESCALE_1 = 2'h0;
  localparam logic [1:0] PRESCALE_4 = 2'h1;
  // Status bit positions
  localparam int STS_MATCH_BIT = 0;
  localparam int STS_WIDTH = 1;
  // Reset values
  localparam logic [7:0] RST_PERIOD_LIMIT = 8'hff;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_PIN_DIRECTION = 1'b1;
  // Oscillator periods per timer increment at 1:1 prescale
  localparam int OSC_PER_INC = 4;
endpackage
`default_nettype wire

// file: verif/tb_top.sv
// Register-driven testbench for the standard PWM block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire logic [7:0] reg_rdata;
  wire logic pwm_o;
  wire logic pwm_oe;
  wire logic irq;
  int err_total = 0;
  int check_count = 0;
  logic [7:0] rv;
  int hi, per, n;
  csp_pwm i_csp_pwm (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pwm_output_pin_o(pwm_o), .pwm_output_pin_oe(pwm_oe), .irq(irq));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // Measures one full high phase and the whole period, sampled once per clock
  task automatic meas(output int h, output int p);
    n = 0;
    while (pwm_o !== 1'b0 && n < 500) begin cyc(1); n++; end
    while (pwm_o !== 1'b1 && n < 1000) begin cyc(1); n++; end
    h = 0;
    while (pwm_o === 1'b1 && h < 1000) begin cyc(1); h++; end
    p = h;
    while (pwm_o !== 1'b1 && p < 1000) begin cyc(1); p++; end
  endtask
  initial begin
    #200us;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(csp_pkg::ADDR_PERIOD_LIMIT, rv); chk(rv, 8'hff, "limit reset");
    rd(csp_pkg::ADDR_PIN_DIRECTION, rv); chk(rv, 8'h01, "direction reset");
    rd(csp_pkg::ADDR_DUTY_ACTIVE, rv); chk(rv, 8'h00, "active reset");
    rd(4'h9, rv); chk(rv, 8'h00, "unmapped read");
    wr(csp_pkg::ADDR_PERIOD_LIMIT, 8'h03);
    wr(csp_pkg::ADDR_CCP_CONTROL, 8'h1c);
    wr(csp_pkg::ADDR_DUTY_STAGING, 8'h02);
    wr(csp_pkg::ADDR_IRQ_STATUS, 8'h01);
    wr(csp_pkg::ADDR_IRQ_MASK, 8'h00);
    wr(csp_pkg::ADDR_TIMER_CONTROL, 8'h04);
    rv = 8'h00;
    for (int i = 0; i < 50 && rv[0] !== 1'b1; i++) rd(csp_pkg::ADDR_IRQ_STATUS, rv);
    chk(rv[0], 1'b1, "match flag");
    chk(irq, 1'b0, "irq masked");
    wr(csp_pkg::ADDR_IRQ_MASK, 8'h01);
    cyc(2); chk(irq, 1'b1, "irq unmasked");
    wr(csp_pkg::ADDR_PIN_DIRECTION, 8'h00);
    cyc(2); chk(pwm_oe, 1'b1, "driver on");
    // First period after enabling the driver may be partial, so take the second
    meas(hi, per); meas(hi, per);
    chk(per, 16, "period 1:1");
    chk(hi, 9, "high 1:1");
    rd(csp_pkg::ADDR_DUTY_ACTIVE, rv); chk(rv, 8'h02, "active copied");
    wr(csp_pkg::ADDR_DUTY_ACTIVE, 8'h55);
    rd(csp_pkg::ADDR_DUTY_ACTIVE, rv); chk(rv, 8'h02, "active read-only");
    wr(csp_pkg::ADDR_TIMER_CONTROL, 8'h05);
    meas(hi, per); meas(hi, per);
    chk(per, 64, "period 1:4");
    chk(hi, 36, "high 1:4");
    wr(csp_pkg::ADDR_DUTY_STAGING, 8'h00);
    wr(csp_pkg::ADDR_CCP_CONTROL, 8'h0c);
    cyc(140);
    n = 0;
    for (int i = 0; i < 130; i++) begin cyc(1); if (pwm_o !== 1'b0) n++; end
    chk(n, 0, "zero duty stays low");
    wr(csp_pkg::ADDR_DUTY_STAGING, 8'h02);
    wr(csp_pkg::ADDR_CCP_CONTROL, 8'h1c);
    wr(csp_pkg::ADDR_TIMER_CONTROL, 8'h06);
    meas(hi, per); meas(hi, per);
    chk(per, 256, "period 1:16");
    chk(hi, 144, "high 1:16");
    wr(csp_pkg::ADDR_TIMER_CONTROL, 8'h00);
    cyc(4);
    wr(csp_pkg::ADDR_TIMEBASE_COUNT, 8'h02);
    rd(csp_pkg::ADDR_TIMEBASE_COUNT, rv); chk(rv, 8'h02, "count write");
    wr(csp_pkg::ADDR_IRQ_STATUS, 8'h01);
    rd(csp_pkg::ADDR_IRQ_STATUS, rv); chk(rv, 8'h00, "flag cleared");
    cyc(2); chk(irq, 1'b0, "irq cleared");
    stop_test();
  end
endmodule
`default_nettype wire
